// [dmc_pkg.sv]
// constants for the demand metering configuration reply framer
package dmc_pkg;
    // ------------------------------------------------------------
    // request codes
    // ------------------------------------------------------------
    localparam logic [7:0]  REQ_LEAD      = 8'ha5;
    localparam logic [7:0]  REQ_DEMAND    = 8'hc2;
    localparam logic [7:0]  REQ_PEAK      = 8'hc3;
    localparam logic [7:0]  REQ_ACK       = 8'hb9;

    // ------------------------------------------------------------
    // reply header fields
    // ------------------------------------------------------------
    localparam logic [7:0]  LEN_BYTE      = 8'he4;
    localparam logic [7:0]  STATUS_BYTES  = 8'h01;
    localparam logic [7:0]  SCALE_IN_MSG  = 8'h00;
    localparam logic [7:0]  SCALE_CNT     = 8'h00;
    localparam logic [7:0]  CHAN_CNT      = 8'h15;
    localparam logic [7:0]  SAMPLES       = 8'h01;
    localparam logic [7:0]  DIG_BANKS     = 8'h00;
    localparam logic [7:0]  CALC_BLOCKS   = 8'h00;
    localparam logic [15:0] ANALOG_OFS    = 16'h0004;
    localparam logic [15:0] TIME_OFS      = 16'h00ac;
    localparam logic [15:0] DIG_OFS       = 16'hffff;
    localparam logic [7:0]  RESERVED_BYTE = 8'h00;

    // ------------------------------------------------------------
    // channel descriptor fields
    // ------------------------------------------------------------
    localparam logic [7:0]  CH_TYPE       = 8'h02;
    localparam logic [7:0]  SF_TYPE       = 8'hff;
    localparam logic [15:0] SF_OFS        = 16'h0000;

    // ------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------
    localparam int          HDR_LEN       = 16;
    localparam int          NAME_LEN      = 6;
    localparam int          DESC_LEN      = 10;
    localparam int          NUM_CH        = 21;
    localparam int          REPLY_LEN     = 228;
    localparam int          FLAG_BIT      = 4;

    // ------------------------------------------------------------
    // channel names, ascii padded with zero bytes, in send order
    // ------------------------------------------------------------
    localparam logic [47:0] CH_NAME [0:20] = '{
        48'h494100000000, 48'h494200000000, 48'h494300000000,
        48'h494700000000, 48'h334932000000,
        48'h50412b000000, 48'h50422b000000, 48'h50432b000000,
        48'h50332b000000, 48'h51412b000000, 48'h51422b000000,
        48'h51432b000000, 48'h51332b000000,
        48'h50412d000000, 48'h50422d000000, 48'h50432d000000,
        48'h50332d000000, 48'h51412d000000, 48'h51422d000000,
        48'h51432d000000, 48'h51332d000000
    };

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } dmc_state_t;
endpackage

// [dmc_reply.sv]
// demand metering configuration reply framer
`timescale 1ns/1ps

// Overview of operation
// (R1) demand or peak request answered by a reply opening with that code
// (R2) length byte e4 follows the two-byte code in both variants
// (R3) next byte declares one status flag byte
// (R4) then no scale factors byte and a zero scale-factor count
// (R5) then analog channel count of twenty-one
// (R6) then one sample per channel
// (R7) then zero digital banks and zero calculation blocks
// (R8) then analog 0004, time stamp 00ac and digital ffff offsets
// (R9) each channel: zero padded name, type 02, scale type ff, offset 0000
// (R10) channels go currents, residual, negative sequence, positive then negative powers
// (R11) a zero reserved byte, then checksum of all preceding reply bytes
// (R12) config changed flag, status bit 4, set on power-up and settings change
// (R13) polling device re-requests configuration when it sees the flag set
// (R14) multi-byte fields most significant first; checksum is low byte of sum
// (R15) bytes go back to back, only after the full request code
module dmc_reply (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    // request bytes from the polling device
    input  wire logic [7:0] rx_data_i,
    input  wire logic       rx_valid_i,
    // settings change event
    input  wire logic       settings_change_i,
    // reply byte stream
    output logic      [7:0] tx_data_o,
    output logic            tx_valid_o,
    input  wire logic       tx_ready_i,
    // metering status byte
    output logic      [7:0] status_byte_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dmc_pkg::dmc_state_t state_q;
    logic                got_lead_q;
    logic [7:0]          code_q;
    logic [7:0]          idx_q;
    logic [4:0]          ch_q;
    logic [3:0]          off_q;
    logic [7:0]          sum_q;
    logic [7:0]          data_q;
    logic                flag_q;
    logic                fire;
    logic                start;
    logic                ack;
    logic [7:0]          idx_d;
    logic [4:0]          ch_d;
    logic [3:0]          off_d;
    logic [7:0]          sum_d;

    assign fire  = (state_q == dmc_pkg::ST_SEND) && tx_ready_i;
    assign start = (state_q == dmc_pkg::ST_IDLE) && rx_valid_i && got_lead_q
                   && (rx_data_i == dmc_pkg::REQ_DEMAND || rx_data_i == dmc_pkg::REQ_PEAK);
    assign ack   = rx_valid_i && got_lead_q && (rx_data_i == dmc_pkg::REQ_ACK);

    // ------------------------------------------------------------
    // byte of the reply at a given position
    // ------------------------------------------------------------
    function automatic logic [7:0] reply_byte(input logic [7:0] idx, input logic [4:0] ch,
                                              input logic [3:0] off, input logic [7:0] code,
                                              input logic [7:0] sum);
        logic [47:0] name;
        name = dmc_pkg::CH_NAME[ch];
        reply_byte = 8'h00;
        if (idx < 8'(dmc_pkg::HDR_LEN)) begin
            case (idx) // see (R14)
                8'h00:   reply_byte = dmc_pkg::REQ_LEAD;          // see (R1)
                8'h01:   reply_byte = code;                       // see (R1)
                8'h02:   reply_byte = dmc_pkg::LEN_BYTE;          // see (R2)
                8'h03:   reply_byte = dmc_pkg::STATUS_BYTES;      // see (R3)
                8'h04:   reply_byte = dmc_pkg::SCALE_IN_MSG;      // see (R4)
                8'h05:   reply_byte = dmc_pkg::SCALE_CNT;         // see (R4)
                8'h06:   reply_byte = dmc_pkg::CHAN_CNT;          // see (R5)
                8'h07:   reply_byte = dmc_pkg::SAMPLES;           // see (R6)
                8'h08:   reply_byte = dmc_pkg::DIG_BANKS;         // see (R7)
                8'h09:   reply_byte = dmc_pkg::CALC_BLOCKS;       // see (R7)
                8'h0a:   reply_byte = dmc_pkg::ANALOG_OFS[15:8];  // see (R8)
                8'h0b:   reply_byte = dmc_pkg::ANALOG_OFS[7:0];
                8'h0c:   reply_byte = dmc_pkg::TIME_OFS[15:8];
                8'h0d:   reply_byte = dmc_pkg::TIME_OFS[7:0];
                8'h0e:   reply_byte = dmc_pkg::DIG_OFS[15:8];
                8'h0f:   reply_byte = dmc_pkg::DIG_OFS[7:0];
                default: reply_byte = 8'h00;
            endcase
        end else if (idx == 8'(dmc_pkg::REPLY_LEN - 1)) begin
            reply_byte = sum;                                     // see (R11)
        end else if (idx == 8'(dmc_pkg::REPLY_LEN - 2)) begin
            reply_byte = dmc_pkg::RESERVED_BYTE;                  // see (R11)
        end else begin
            case (off) // see (R9)
                4'h6:    reply_byte = dmc_pkg::CH_TYPE;
                4'h7:    reply_byte = dmc_pkg::SF_TYPE;
                4'h8:    reply_byte = dmc_pkg::SF_OFS[15:8];
                4'h9:    reply_byte = dmc_pkg::SF_OFS[7:0];
                default: reply_byte = name[8'(47 - 8 * off) -: 8]; // see (R10)
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // next position along the reply
    // ------------------------------------------------------------
    always_comb begin
        idx_d = idx_q + 8'h01;
        sum_d = sum_q + data_q;                                   // see (R14)
        ch_d  = ch_q;
        off_d = off_q;
        if (idx_q >= 8'(dmc_pkg::HDR_LEN)) begin
            if (off_q == 4'(dmc_pkg::DESC_LEN - 1)) begin
                off_d = 4'h0;
                ch_d  = ch_q + 5'h01;
            end else begin
                off_d = off_q + 4'h1;
            end
        end
        if (ch_d > 5'(dmc_pkg::NUM_CH - 1)) begin
            ch_d = 5'(dmc_pkg::NUM_CH - 1);
        end
    end

    // ------------------------------------------------------------
    // request parser
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            got_lead_q <= 1'b0;
        end else if (rx_valid_i) begin
            got_lead_q <= (rx_data_i == dmc_pkg::REQ_LEAD);
        end
    end

    // ------------------------------------------------------------
    // reply sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            state_q <= dmc_pkg::ST_IDLE;
            code_q  <= 8'h00;
            idx_q   <= 8'h00;
            ch_q    <= 5'h00;
            off_q   <= 4'h0;
            sum_q   <= 8'h00;
            data_q  <= 8'h00;
        end else begin
            case (state_q)
                dmc_pkg::ST_IDLE: begin
                    if (start) begin                              // see (R15)
                        state_q <= dmc_pkg::ST_SEND;
                        code_q  <= rx_data_i;
                        idx_q   <= 8'h00;
                        ch_q    <= 5'h00;
                        off_q   <= 4'h0;
                        sum_q   <= 8'h00;
                        data_q  <= dmc_pkg::REQ_LEAD;             // see (R1)
                    end
                end
                dmc_pkg::ST_SEND: begin
                    if (fire) begin                               // see (R15)
                        if (idx_q == 8'(dmc_pkg::REPLY_LEN - 1)) begin
                            state_q <= dmc_pkg::ST_IDLE;
                        end else begin
                            idx_q  <= idx_d;
                            ch_q   <= ch_d;
                            off_q  <= off_d;
                            sum_q  <= sum_d;
                            data_q <= reply_byte(idx_d, ch_d, off_d, code_q, sum_d);
                        end
                    end
                end
                default: state_q <= dmc_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // config changed flag, set wins over acknowledge
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b1;                                       // see (R12)
        end else if (settings_change_i) begin
            flag_q <= 1'b1;                                       // see (R12)
        end else if (ack) begin
            flag_q <= 1'b0;                                       // see (R12)
        end
    end

    assign tx_data_o     = data_q;
    assign tx_valid_o    = (state_q == dmc_pkg::ST_SEND);
    assign status_byte_o = 8'(flag_q) << dmc_pkg::FLAG_BIT;

    // ------------------------------------------------------------
    // check helpers, counted from accepted bytes only
    // ------------------------------------------------------------
    logic [7:0]          seen_sum_q;
    logic [7:0]          seen_pos_q;
    logic [7:0]          seen_off;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !tx_valid_o) begin
            seen_sum_q <= 8'h00;
        end else if (tx_ready_i) begin
            seen_sum_q <= seen_sum_q + tx_data_o;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !tx_valid_o) begin
            seen_pos_q <= 8'h00;
        end else if (tx_ready_i) begin
            seen_pos_q <= seen_pos_q + 8'h01;
        end
    end

    // byte offset inside a channel descriptor
    assign seen_off = (seen_pos_q - 8'h10) % 8'h0a;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    chk_open_code: assert property ($rose(tx_valid_o) |-> tx_data_o == 8'ha5 // see (R1)
        && $past(got_lead_q && rx_valid_i) && code_q == $past(rx_data_i)
        && code_q inside {8'hc2, 8'hc3})
        else $error("reply does not open with the requested code");
    chk_variant_echo: assert property (tx_valid_o && seen_pos_q == 8'h01 |-> // see (R1)
        tx_data_o == code_q && code_q inside {8'hc2, 8'hc3})
        else $error("second reply byte differs from request");
    chk_length_byte: assert property (tx_valid_o && idx_q == 8'h02 |-> // see (R2)
        tx_data_o == 8'he4) else $error("length byte wrong");
    chk_status_count: assert property (tx_valid_o && idx_q == 8'h03 |-> // see (R3)
        tx_data_o == 8'h01) else $error("status byte count wrong");
    chk_scale_none: assert property (tx_valid_o && idx_q inside {8'h04, 8'h05} |-> // see (R4)
        tx_data_o == 8'h00) else $error("scale factor bytes not zero");
    chk_chan_count: assert property (tx_valid_o && idx_q == 8'h06 |-> // see (R5)
        tx_data_o == 8'h15) else $error("channel count wrong");
    chk_samples_one: assert property (tx_valid_o && idx_q == 8'h07 |-> // see (R6)
        tx_data_o == 8'h01) else $error("samples per channel wrong");
    chk_banks_zero: assert property (tx_valid_o && idx_q inside {8'h08, 8'h09} |-> // see (R7)
        tx_data_o == 8'h00) else $error("bank or block count not zero");
    chk_time_offset: assert property (tx_valid_o && seen_pos_q[7:1] == 7'h06 |-> // see (R8)
        tx_data_o == (seen_pos_q[0] ? 8'hac : 8'h00)) else $error("time stamp offset wrong");
    chk_desc_type: assert property (tx_valid_o && idx_q >= 8'h10 && idx_q < 8'he2 // see (R9)
        && off_q == 4'h6 |-> tx_data_o == 8'h02) else $error("channel type not double");
    chk_last_name: assert property (tx_valid_o && ch_q == 5'h14 && off_q == 4'h2 // see (R10)
        && idx_q >= 8'h10 |-> tx_data_o == 8'h2d) else $error("last channel name wrong");
    chk_checksum: assert property (tx_valid_o && seen_pos_q == 8'he3 |-> // see (R11)
        tx_data_o == seen_sum_q) else $error("checksum wrong");
    chk_flag_clear: assert property (ack && !settings_change_i |=> // see (R12)
        status_byte_o == 8'h00) else $error("acknowledge did not clear flag");
    chk_back_to_back: assert property (tx_valid_o && tx_ready_i && idx_q < 8'he3 |=> // see (R15)
        tx_valid_o && idx_q == $past(idx_q) + 8'h01) else $error("reply stalled");

    chk_analog_offset: assert property (tx_valid_o && seen_pos_q[7:1] == 7'h05 |-> // see (R8)
        tx_data_o == (seen_pos_q[0] ? 8'h04 : 8'h00))
        else $error("analog channel offset wrong");
    chk_digital_offset: assert property (tx_valid_o && seen_pos_q[7:1] == 7'h07 |-> // see (R8)
        tx_data_o == 8'hff)
        else $error("digital offset not ffff");
    chk_name_pad: assert property (tx_valid_o && seen_pos_q inside {[8'h10:8'he1]} // see (R9)
        && seen_off inside {8'h03, 8'h04, 8'h05} |-> tx_data_o == 8'h00)
        else $error("channel name not zero padded");
    chk_scale_type: assert property (tx_valid_o && seen_pos_q inside {[8'h10:8'he1]} // see (R9)
        && seen_off == 8'h07 |-> tx_data_o == 8'hff)
        else $error("scale factor type not ff");
    chk_scale_offset: assert property (tx_valid_o && seen_pos_q inside {[8'h10:8'he1]} // see (R9)
        && seen_off inside {8'h08, 8'h09} |-> tx_data_o == 8'h00)
        else $error("scale factor offset not zero");
    chk_first_name: assert property (tx_valid_o && seen_pos_q[7:1] == 7'h08 |-> // see (R10)
        tx_data_o == (seen_pos_q[0] ? 8'h41 : 8'h49))
        else $error("first channel name wrong");
    chk_reserved_byte: assert property (tx_valid_o && seen_pos_q == 8'he2 |-> // see (R11)
        tx_data_o == 8'h00)
        else $error("reserved byte not zero");
    chk_reply_end: assert property (tx_valid_o && tx_ready_i && seen_pos_q == 8'he3 // see (R11)
        |=> !tx_valid_o)
        else $error("reply runs past its checksum");
    chk_data_hold: assert property (tx_valid_o && !tx_ready_i |=> // see (R15)
        tx_valid_o && $stable(tx_data_o))
        else $error("reply byte changed while stalled");
    chk_busy_ignored: assert property (tx_valid_o && rx_valid_i && got_lead_q |=> // see (R15)
        code_q == $past(code_q) && idx_q >= $past(idx_q))
        else $error("request restarted a reply in progress");
    chk_flag_set: assert property (settings_change_i |=> // see (R12)
        status_byte_o == 8'h10)
        else $error("settings change did not set flag");
    chk_position_sync: assert property (tx_valid_o |-> // see (R15)
        idx_q == seen_pos_q)
        else $error("reply position out of step");

    cov_demand: cover property ($rose(tx_valid_o) && code_q == 8'hc2);
    cov_peak: cover property ($rose(tx_valid_o) && code_q == 8'hc3);
    cov_done: cover property (tx_valid_o && tx_ready_i && idx_q == 8'he3);
    cov_set_ack: cover property (ack && settings_change_i);
    cov_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule // dmc_reply

// [dmc_poller.sv]
// polling device model: sends request codes and drains the reply stream
`timescale 1ns/1ps
module dmc_poller (
    // clock and pacing, pacing high stalls the sink every other cycle
    input  wire logic       mclk_i,
    input  wire logic       slow_i,
    // request bytes toward the framer
    output logic      [7:0] rx_data_o,
    output logic            rx_valid_o,
    // reply stream from the framer
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o
);
    logic [7:0] got [$];
    logic       tick_q;

    initial begin
        rx_data_o  = 8'h00;
        rx_valid_o = 1'b0;
        tick_q     = 1'b0;
    end

    // released data line shows the inverse of the last byte
    task automatic send_byte(input logic [7:0] b);
        @(posedge mclk_i);
        rx_data_o  <= b;
        rx_valid_o <= 1'b1;
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~b;
    endtask

    // lead byte then code, used again whenever the changed flag is seen
    task automatic send_req(input logic [7:0] code);
        send_byte(dmc_pkg::REQ_LEAD);
        send_byte(code);
    endtask

    always @(posedge mclk_i) begin
        tick_q <= ~tick_q;
    end

    assign tx_ready_o = slow_i ? tick_q : 1'b1;

    // accepted bytes kept in arrival order
    always @(posedge mclk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
        end
    end
endmodule // dmc_poller

// [demand_meter_config_reply_tb_top.sv]
// self-checking bench for the demand metering configuration reply framer
`timescale 1ns/1ps
module demand_meter_config_reply_tb_top;
    logic       mclk            = 1'b0;
    logic       resetn          = 1'b0;
    logic       settings_change = 1'b0;
    logic       slow            = 1'b0;
    logic [7:0] rx_data;
    logic       rx_valid;
    logic [7:0] tx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] status_byte;
    logic [7:0] exp_q [$];
    int         fails           = 0;
    int         comparisons     = 0;

    always #5 mclk = ~mclk;

    dmc_reply u_dmc_reply (.mclk_i(mclk), .resetn_i(resetn), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .settings_change_i(settings_change), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .status_byte_o(status_byte));
    dmc_poller u_dmc_poller (.mclk_i(mclk), .slow_i(slow), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset;
        resetn <= 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        check({7'h00, tx_valid}, 8'h00);
        check(status_byte, 8'h10);
    endtask

    // expected reply worked out field by field
    task automatic build(input logic [7:0] code);
        logic [7:0] sum;
        exp_q = {dmc_pkg::REQ_LEAD, code, 8'he4};
        exp_q = {exp_q, 8'h01, 8'h00, 8'h00, 8'h15, 8'h01};
        exp_q = {exp_q, 8'h00, 8'h00};
        exp_q = {exp_q, 8'h00, 8'h04, 8'h00, 8'hac, 8'hff, 8'hff};
        for (int c = 0; c < dmc_pkg::NUM_CH; c++) begin
            for (int k = 5; k >= 0; k--) begin
                exp_q.push_back(dmc_pkg::CH_NAME[c][k*8 +: 8]);
            end
            exp_q = {exp_q, 8'h02, 8'hff, 8'h00, 8'h00};
        end
        exp_q.push_back(8'h00);
        sum = 8'h00;
        foreach (exp_q[i]) begin
            sum += exp_q[i];
        end
        exp_q.push_back(sum);
    endtask

    task automatic cmp_frame;
        check(8'(u_dmc_poller.got.size()), 8'(dmc_pkg::REPLY_LEN));
        check({7'h00, tx_valid}, 8'h00);
        foreach (exp_q[i]) begin
            check(u_dmc_poller.got[i], exp_q[i]);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reply(input logic [7:0] code, input logic pace);
        slow <= pace;
        build(code);
        u_dmc_poller.got.delete();
        u_dmc_poller.send_req(code);
        // unstalled the whole reply fits in 228 cycles
        repeat (pace ? 600 : 230) @(posedge mclk);
        cmp_frame();
        $display("test reply %h pace %0d done", code, pace);
    endtask

    task automatic t_busy;
        slow <= 1'b0;
        build(dmc_pkg::REQ_DEMAND);
        u_dmc_poller.got.delete();
        u_dmc_poller.send_req(dmc_pkg::REQ_DEMAND);
        repeat (40) @(posedge mclk);
        u_dmc_poller.send_req(dmc_pkg::REQ_PEAK);
        repeat (230) @(posedge mclk);
        cmp_frame();
        $display("test busy request done");
    endtask

    task automatic t_partial;
        u_dmc_poller.got.delete();
        u_dmc_poller.send_byte(dmc_pkg::REQ_LEAD);
        u_dmc_poller.send_byte(8'h00);
        u_dmc_poller.send_byte(dmc_pkg::REQ_DEMAND);
        u_dmc_poller.send_byte(dmc_pkg::REQ_PEAK);
        repeat (20) @(posedge mclk);
        check(8'(u_dmc_poller.got.size()), 8'h00);
        $display("test partial code done");
    endtask

    task automatic t_flag;
        u_dmc_poller.send_req(dmc_pkg::REQ_ACK);
        repeat (2) @(posedge mclk);
        check(status_byte, 8'h00);
        settings_change <= 1'b1;
        @(posedge mclk);
        settings_change <= 1'b0;
        repeat (2) @(posedge mclk);
        check(status_byte, 8'h10);
        settings_change <= 1'b1;
        u_dmc_poller.send_req(dmc_pkg::REQ_ACK);
        settings_change <= 1'b0;
        repeat (2) @(posedge mclk);
        check(status_byte, 8'h10);
        $display("test changed flag done");
    endtask

    // polling side answers a set changed flag by asking for both replies again
    task automatic t_reconfig;
        settings_change <= 1'b1;
        @(posedge mclk);
        settings_change <= 1'b0;
        repeat (2) @(posedge mclk);
        check(status_byte, 8'h10);
        if (status_byte[dmc_pkg::FLAG_BIT] === 1'b1) begin
            t_reply(dmc_pkg::REQ_DEMAND, 1'b0);
            t_reply(dmc_pkg::REQ_PEAK, 1'b0);
        end
        u_dmc_poller.send_req(dmc_pkg::REQ_ACK);
        repeat (2) @(posedge mclk);
        check(status_byte, 8'h00);
        $display("test re-request on changed flag done");
    endtask

    task automatic t_midreset;
        u_dmc_poller.got.delete();
        u_dmc_poller.send_req(dmc_pkg::REQ_PEAK);
        repeat (20) @(posedge mclk);
        do_reset();
        u_dmc_poller.got.delete();
        repeat (5) @(posedge mclk);
        check(8'(u_dmc_poller.got.size()), 8'h00);
        $display("test reset mid reply done");
    endtask

    initial begin
        do_reset();
        t_partial();
        t_reply(dmc_pkg::REQ_DEMAND, 1'b0);
        t_reply(dmc_pkg::REQ_PEAK, 1'b1);
        t_busy();
        t_flag();
        t_reconfig();
        t_midreset();
        t_reply(dmc_pkg::REQ_PEAK, 1'b0);
        report_and_stop();
    end

    // whole run is about 1900 cycles
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule // demand_meter_config_reply_tb_top
